/* ee_partner.sv */
// Behavioural EEPROM word source answering the loader fetches
`timescale 1ns/10ps
module ee_partner (
   input wire clk,
   input wire req,
   input wire [7:0] addr,
   input wire fail,
   output reg ack,
   output reg err,
   output reg [15:0] data
);
   // Control image sets every bit but start, so skipped bits show up
   localparam [15:0] MASK_IMG = 16'h00a5;
   localparam [15:0] CTRL_IMG = 16'hdfff;
   reg [2:0] cnt_q = 3'h0;
   initial begin
      ack = 1'b0;
      err = 1'b0;
      data = 16'h0000;
   end
   // Waits four cycles per word so the address has settled first
   always @(posedge clk) begin
      ack <= 1'b0;
      err <= 1'b0;
      if (req && !ack && cnt_q == 3'h3) begin
         ack <= 1'b1;
         err <= fail;
         data <= (addr == 8'h00) ? MASK_IMG : CTRL_IMG;
         cnt_q <= 3'h0;
      end else begin
         cnt_q <= (req && !ack) ? cnt_q + 3'h1 : 3'h0;
         // Outside an answer the data bus keeps changing
         data <= ~data;
      end
   end
endmodule

/* eeprom_loader.v */
// EEPROM auto-load sequencer: fetches the mask word, then the control word
`timescale 1ns/10ps
`include "learn_ctrl_defs.vh"

module eeprom_loader (
   input wire clk,
   input wire rst_n,
   input wire kick,
   input wire ee_absent,
   input wire ee_ack,
   input wire ee_err,
   input wire [15:0] ee_data,
   output reg ee_req_q,
   output reg [7:0] ee_addr_q,
   output reg busy_q,
   output reg done_q,
   output reg fail_q,
   output reg mask_wr_q,
   output reg ctrl_wr_q,
   output reg [15:0] word_q
);

   localparam IDLE = `LD_IDLE;
   localparam REQ_MASK = `LD_REQ_MASK;
   localparam REQ_CTRL = `LD_REQ_CTRL;

   reg [2:0] state_q;

   always @(posedge clk) begin
      if (!rst_n) begin
         state_q <= IDLE;
         ee_req_q <= 1'b0;
         ee_addr_q <= `EE_ADDR_RST;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         fail_q <= 1'b0;
         mask_wr_q <= 1'b0;
         ctrl_wr_q <= 1'b0;
         word_q <= `RST_WORD;
      end else begin
         done_q <= 1'b0;
         fail_q <= 1'b0;
         mask_wr_q <= 1'b0;
         ctrl_wr_q <= 1'b0;
         case (state_q)
            IDLE: begin
               if (kick && ee_absent) begin
                  // Nothing to fetch: finish at once, no failure
                  done_q <= 1'b1;
               end else if (kick) begin
                  busy_q <= 1'b1;
                  ee_req_q <= 1'b1;
                  ee_addr_q <= `EE_ADDR_MASK;
                  state_q <= REQ_MASK;
               end
            end
            REQ_MASK: begin
               if (ee_ack && ee_err) begin
                  ee_req_q <= 1'b0;
                  busy_q <= 1'b0;
                  fail_q <= 1'b1; // [R06]
                  state_q <= IDLE;
               end else if (ee_ack) begin
                  mask_wr_q <= 1'b1; // [R03]
                  word_q <= ee_data;
                  ee_addr_q <= `EE_ADDR_CTRL;
                  state_q <= REQ_CTRL;
               end
            end
            REQ_CTRL: begin
               if (ee_ack) begin
                  ee_req_q <= 1'b0;
                  busy_q <= 1'b0;
                  state_q <= IDLE;
                  if (ee_err) begin
                     fail_q <= 1'b1; // [R06]
                  end else begin
                     ctrl_wr_q <= 1'b1;
                     word_q <= ee_data;
                     done_q <= 1'b1; // [R09]
                  end
               end
            end
            default: begin
               state_q <= IDLE;
               ee_req_q <= 1'b0;
               busy_q <= 1'b0;
            end
         endcase
      end
   end

endmodule

/* learn_ctrl_defs.vh */
// Constants for the mode-control and learning-disable register bank
`ifndef LEARN_CTRL_DEFS_VH
`define LEARN_CTRL_DEFS_VH

// Direct I/O register offsets
`define OFS_LEARN_MASK 8'h04
`define OFS_MODE_CTRL 8'h08

// Address-high value that requests a reload
`define ADDR_HI_RELOAD 8'h40

// Mode-control field positions
`define BIT_SOFT_RST 15
`define BIT_LOAD 14
`define BIT_START 13
`define BIT_INIT_DONE 12
`define BIT_NO_EEPROM 11
`define BIT_MANUAL_ADD 10

// Reset values
`define RST_LEARN_MASK 16'h0000
`define RST_WORD 16'h0000

// EEPROM word addresses for the loaded images
`define EE_ADDR_MASK 8'h00
`define EE_ADDR_CTRL 8'h01
`define EE_ADDR_RST 8'h00

// Timing
`define CLK_PERIOD_NS 10
`define INIT_BASE_NS 40000
`define INIT_ENTRY_NS 40
`define INIT_CNT_ZERO 24'h000000
`define INIT_CNT_ONE 24'h000001

// Loader states
`define LD_IDLE 3'h0
`define LD_REQ_MASK 3'h1
`define LD_REQ_CTRL 3'h2

`endif

/* mcl_properties.sv */
// Concurrent checks on the mode-control register bank ports
`timescale 1ns/10ps
module mcl_properties #(
   parameter INIT_BASE_NS = 40000
) (
   input wire CLOCK,
   input wire RST_N,
   input wire DIO_RD,
   input wire DIO_RVALID,
   input wire EE_REQ,
   input wire [7:0] EE_ADDR,
   input wire EE_ACK,
   input wire EE_ERR,
   input wire SRC_UNKNOWN,
   input wire [3:0] SRC_PORT,
   input wire ADD_CMD,
   input wire AUTO_ADD,
   input wire [3:0] AUTO_ADD_PORT,
   input wire MANUAL_ADD,
   input wire MATCH_EN,
   input wire AGING_EN,
   input wire LOGIC_RESET,
   input wire TABLE_INIT_BUSY
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////////////////////////////////////
   rd_answer_a: assert property (DIO_RD |=> DIO_RVALID)
      else $error("read not answered");
   rvalid_cause_a: assert property (DIO_RVALID |-> $past(DIO_RD))
      else $error("read valid without read");
   auto_cause_a: assert property (AUTO_ADD |->
      $past(SRC_UNKNOWN) && AUTO_ADD_PORT == $past(SRC_PORT))
      else $error("auto add without unknown source");
   manual_cause_a: assert property (MANUAL_ADD |->
      $past(ADD_CMD) && !AUTO_ADD)
      else $error("manual add without command");
   aging_mode_a: assert property (AGING_EN |-> MATCH_EN && !MANUAL_ADD)
      else $error("aging outside automatic operation");
   match_gate_a: assert property (MATCH_EN |->
      !TABLE_INIT_BUSY && !LOGIC_RESET)
      else $error("matching during init or reset");
   soft_hold_a: assert property (LOGIC_RESET |-> !AUTO_ADD && !AGING_EN)
      else $error("activity in soft reset");
   load_fail_a: assert property (EE_REQ && EE_ACK && EE_ERR |->
      ##[1:4] LOGIC_RESET)
      else $error("failed load did not set soft reset");
   fetch_addr_a: assert property (EE_REQ |-> EE_ADDR <= 8'h01)
      else $error("fetch address out of image");
   cover property (AUTO_ADD);
   cover property (MANUAL_ADD);
   cover property (EE_ACK && EE_ERR);
   cover property ($rose(MATCH_EN));
endmodule
bind mode_control_learn_disable mcl_properties #(
   .INIT_BASE_NS(INIT_BASE_NS)) i_mcl_properties (
   .CLOCK(CLOCK), .RST_N(RST_N), .DIO_RD(DIO_RD),
   .DIO_RVALID(DIO_RVALID), .EE_REQ(EE_REQ), .EE_ADDR(EE_ADDR),
   .EE_ACK(EE_ACK), .EE_ERR(EE_ERR), .SRC_UNKNOWN(SRC_UNKNOWN),
   .SRC_PORT(SRC_PORT), .ADD_CMD(ADD_CMD), .AUTO_ADD(AUTO_ADD),
   .AUTO_ADD_PORT(AUTO_ADD_PORT), .MANUAL_ADD(MANUAL_ADD),
   .MATCH_EN(MATCH_EN), .AGING_EN(AGING_EN),
   .LOGIC_RESET(LOGIC_RESET), .TABLE_INIT_BUSY(TABLE_INIT_BUSY));

/* mode_control_learn_disable.v */
// Mode-control and learning-disable register bank of the lookup engine
//
// Summary of operation
// R01: Masked ports still route frames but never learn source addresses.
// R02: Learning-disable mask is readable and writable at any time; here soft reset holds it at 0 and drops host writes.
// R03: Mask reloads from EEPROM on reset pin, address-high 0x40, or load bit.
// R04: Loader skips soft reset and load bits to avoid self retriggering.
// R05: Init-done and no-EEPROM bits are set only by status logic.
// R06: Failed auto-load sets soft reset bit, holding the device in reset.
// R07: Soft reset clears logic and all registers but control, drops table; here it also clears the start and load bits.
// R08: Host must write 0 to soft reset bit to leave reset.
// R09: Load bit starts auto-load, loader clears it, writing 0 does nothing.
// R10: Start bit begins operation; no address checks during table init.
// R11: Init-done rises after table init; learning and matching wait for it.
// R12: Table init lasts base interval plus 40 ns per external entry.
// R13: No-EEPROM bit reads 1 without EEPROM, 0 with one.
// R14: In manual-add mode entries are added only on direct I/O command.
// R15: Outside manual-add mode unknown sources are added automatically.
// R16: Manual-add mode disables aging entirely.
// R17: Host should not change manual-add bit after start.
// R18: Load bit reads 1 during auto-load; further load writes ignored.
`timescale 1ns/10ps
`include "learn_ctrl_defs.vh"

module mode_control_learn_disable #(
   parameter INIT_BASE_NS = `INIT_BASE_NS
) (
   input wire CLOCK,
   input wire RST_N,
   input wire [7:0] DIO_ADDR,
   input wire [15:0] DIO_WDATA,
   input wire DIO_WR,
   input wire DIO_RD,
   input wire DIO_HI_WR,
   input wire [7:0] DIO_HI_DATA,
   output reg [15:0] DIO_RDATA,
   output reg DIO_RVALID,
   input wire EE_ABSENT,
   output reg EE_REQ,
   output reg [7:0] EE_ADDR,
   input wire EE_ACK,
   input wire EE_ERR,
   input wire [15:0] EE_DATA,
   input wire [15:0] RAM_SIZE,
   input wire SRC_UNKNOWN,
   input wire [3:0] SRC_PORT,
   input wire ADD_CMD,
   output reg AUTO_ADD,
   output reg [3:0] AUTO_ADD_PORT,
   output reg MANUAL_ADD,
   output reg [15:0] LEARN_EN,
   output reg MATCH_EN,
   output reg AGING_EN,
   output reg LOGIC_RESET,
   output reg TABLE_INIT_BUSY
);

   // Cycle counts from the nanosecond figures, rounded up per entry
   localparam integer BASE_INT = INIT_BASE_NS / `CLK_PERIOD_NS;
   localparam integer ENTRY_INT =
      (`INIT_ENTRY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   // Cut to the timer widths on purpose; defaults fit with room to spare
   localparam [23:0] BASE_CYCLES = BASE_INT[23:0];
   localparam [3:0] ENTRY_CYCLES = ENTRY_INT[3:0];

   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser and boot request
   // The presence pin is asynchronous: two flops before any use

   reg absent_meta_q;
   reg absent_q;
   reg boot_q;

   always @(posedge CLOCK) begin
      if (!RST_N) begin
         absent_meta_q <= 1'b0;
         absent_q <= 1'b0;
      end else begin
         absent_meta_q <= EE_ABSENT;
         absent_q <= absent_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register state

   reg [15:0] learn_mask_q;
   reg soft_rst_q;
   reg load_q;
   reg start_q;
   reg no_eeprom_q;
   reg manual_add_mode_q;

   // Read-only and reserved control bits are simply never stored
   wire wr_mask = DIO_WR && (DIO_ADDR == `OFS_LEARN_MASK);
   wire wr_ctrl = DIO_WR && (DIO_ADDR == `OFS_MODE_CTRL);
   wire hi_reload = DIO_HI_WR && (DIO_HI_DATA == `ADDR_HI_RELOAD);
   wire host_load = wr_ctrl && DIO_WDATA[`BIT_LOAD];

   wire ld_busy;
   wire ld_done;
   wire ld_fail;
   wire ld_mask_wr;
   wire ld_ctrl_wr;
   wire [15:0] ld_word;
   wire ld_req;
   wire [7:0] ld_addr;
   wire init_busy;
   wire init_done;

   // A trigger while a load runs is dropped, so loads never overlap.
   // Soft reset holds the loader too; a boot request waits it out.
   wire kick = !ld_busy && !load_q && !soft_rst_q &&
               (boot_q || hi_reload || host_load); // [R03] [R18]

   // Soft reset parks the loader so a half-done fetch cannot land later
   wire ld_rst_n = RST_N && !soft_rst_q; // [R07]

   eeprom_loader u_loader (
      .clk(CLOCK),
      .rst_n(ld_rst_n),
      .kick(kick),
      .ee_absent(absent_q),
      .ee_ack(EE_ACK),
      .ee_err(EE_ERR),
      .ee_data(EE_DATA),
      .ee_req_q(ld_req),
      .ee_addr_q(ld_addr),
      .busy_q(ld_busy),
      .done_q(ld_done),
      .fail_q(ld_fail),
      .mask_wr_q(ld_mask_wr),
      .ctrl_wr_q(ld_ctrl_wr),
      .word_q(ld_word)
   );

   // Boot load waits for the synchroniser to settle on the presence pin
   reg [1:0] boot_wait_q;

   always @(posedge CLOCK) begin
      if (!RST_N) begin
         boot_q <= 1'b0;
         boot_wait_q <= 2'b00;
      end else begin
         if (boot_wait_q != 2'b11) begin
            boot_wait_q <= boot_wait_q + 2'b01;
         end
         if (boot_wait_q == 2'b10) begin
            boot_q <= 1'b1; // [R03]
         end else if (kick) begin
            boot_q <= 1'b0;
         end
      end
   end

   // Start written or loaded as 1 while stopped begins table init
   wire start_set = (wr_ctrl && DIO_WDATA[`BIT_START]) ||
                    (ld_ctrl_wr && ld_word[`BIT_START]);

   table_init #(
      .BASE_CYCLES(BASE_CYCLES),
      .ENTRY_CYCLES(ENTRY_CYCLES)
   ) u_init (
      .clk(CLOCK),
      .rst_n(RST_N),
      .clear(soft_rst_q),
      .go(start_q),
      .ram_size(RAM_SIZE),
      .busy_q(init_busy),
      .done_q(init_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // Learning-disable mask
   // Loader word wins over a host write landing in the same cycle

   always @(posedge CLOCK) begin
      if (!RST_N) begin
         learn_mask_q <= `RST_LEARN_MASK;
      end else if (soft_rst_q) begin
         learn_mask_q <= `RST_LEARN_MASK; // [R07]
      end else if (ld_mask_wr) begin
         learn_mask_q <= ld_word; // [R03]
      end else if (wr_mask) begin
         learn_mask_q <= DIO_WDATA; // [R02]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode-control bits

   // No-EEPROM flag follows the synchronised pin; nothing else writes it
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         no_eeprom_q <= 1'b0;
      end else begin
         no_eeprom_q <= absent_q; // [R13] [R05]
      end
   end

   // Loader failure wins over a host clear in the same cycle
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         soft_rst_q <= 1'b0;
      end else if (ld_fail) begin
         soft_rst_q <= 1'b1; // [R06]
      end else if (wr_ctrl) begin
         soft_rst_q <= DIO_WDATA[`BIT_SOFT_RST]; // [R07] [R08]
      end
   end

   // Load bit stands for the whole sequence; a parked loader drops it
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         load_q <= 1'b0;
      end else if (kick) begin
         load_q <= 1'b1; // [R09] [R18]
      end else if (ld_done || ld_fail || soft_rst_q) begin
         load_q <= 1'b0; // [R09]
      end
   end

   // Only a 1 moves start; soft reset is the one way back to stopped
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         start_q <= 1'b0;
      end else if (soft_rst_q) begin
         start_q <= 1'b0; // [R07]
      end else if (start_set) begin
         start_q <= 1'b1; // [R10]
      end
   end

   // Loaded word touches only start and manual-add bits
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         manual_add_mode_q <= 1'b0;
      end else if (ld_ctrl_wr) begin
         manual_add_mode_q <= ld_word[`BIT_MANUAL_ADD]; // [R04] [R05]
      end else if (wr_ctrl) begin
         manual_add_mode_q <= DIO_WDATA[`BIT_MANUAL_ADD]; // [R17]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port

   reg [15:0] ctrl_view;

   always @* begin
      // Reserved bits read as zero
      ctrl_view = `RST_WORD;
      ctrl_view[`BIT_SOFT_RST] = soft_rst_q;
      ctrl_view[`BIT_LOAD] = load_q; // [R18]
      ctrl_view[`BIT_START] = start_q;
      ctrl_view[`BIT_INIT_DONE] = init_done; // [R11]
      ctrl_view[`BIT_NO_EEPROM] = no_eeprom_q; // [R13]
      ctrl_view[`BIT_MANUAL_ADD] = manual_add_mode_q;
   end

   // Valid marks the one cycle after a read strobe
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         DIO_RVALID <= 1'b0;
      end else begin
         DIO_RVALID <= DIO_RD; // [R02]
      end
   end

   // Data holds between reads so a slow host may sample it late
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         DIO_RDATA <= `RST_WORD;
      end else if (DIO_RD) begin
         case (DIO_ADDR)
            `OFS_LEARN_MASK: DIO_RDATA <= learn_mask_q; // [R02]
            `OFS_MODE_CTRL: DIO_RDATA <= ctrl_view;
            // Unmapped offsets read as zero
            default: DIO_RDATA <= `RST_WORD;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Engine enables and add requests

   // Active only once started, table ready and out of soft reset
   wire active = start_q && init_done && !soft_rst_q; // [R10] [R11]

   // Add requests: one cycle after the source pulse, gated by mode
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         AUTO_ADD <= 1'b0;
         AUTO_ADD_PORT <= 4'h0;
         MANUAL_ADD <= 1'b0;
      end else begin
         AUTO_ADD <= SRC_UNKNOWN && active && !manual_add_mode_q &&
                     !learn_mask_q[SRC_PORT]; // [R15] [R01]
         AUTO_ADD_PORT <= SRC_PORT;
         MANUAL_ADD <= ADD_CMD && active && manual_add_mode_q; // [R14]
      end
   end

   // Engine enables and status mirrors
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         MATCH_EN <= 1'b0;
         AGING_EN <= 1'b0;
         LOGIC_RESET <= 1'b0;
         TABLE_INIT_BUSY <= 1'b0;
      end else begin
         MATCH_EN <= active; // [R10] [R01]
         AGING_EN <= active && !manual_add_mode_q; // [R16]
         LOGIC_RESET <= soft_rst_q; // [R07]
         TABLE_INIT_BUSY <= init_busy;
      end
   end

   // Fetch request and address re-registered so the pins come from flops
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         EE_REQ <= 1'b0;
         EE_ADDR <= `EE_ADDR_RST;
      end else begin
         EE_REQ <= ld_req;
         EE_ADDR <= ld_addr;
      end
   end

   // Learning needs automatic mode on top of the common gate
   wire learn_ok = active && !manual_add_mode_q;

   genvar i;
   generate
      for (i = 0; i < 16; i = i + 1) begin : g_learn
         always @(posedge CLOCK) begin
            if (!RST_N) begin
               LEARN_EN[i] <= 1'b0;
            end else begin
               LEARN_EN[i] <= learn_ok && !learn_mask_q[i]; // [R01]
            end
         end
      end
   endgenerate

endmodule

/* mode_control_learn_disable_tb_top.sv */
// Self-checking bench for the mode-control register bank
`timescale 1ns/10ps
`define CHK(a, b) begin check_count = check_count + 1; \
   if ((a) !== (b)) begin err_total = err_total + 1; \
   $display("[ERR] %0t mismatch got %h exp %h", $time, a, b); end end
module mode_control_learn_disable_tb_top;
   reg CLOCK = 1'b0;
   reg RST_N = 1'b0;
   reg [7:0] DIO_ADDR = 8'h00;
   reg [15:0] DIO_WDATA = 16'h0000;
   reg DIO_WR = 1'b0;
   reg DIO_RD = 1'b0;
   reg DIO_HI_WR = 1'b0;
   reg [7:0] DIO_HI_DATA = 8'h00;
   reg EE_ABSENT = 1'b0;
   reg SRC_UNKNOWN = 1'b0;
   reg [3:0] SRC_PORT = 4'h0;
   reg ADD_CMD = 1'b0;
   reg ee_fail = 1'b0;
   reg [15:0] RAM_SIZE = 16'h0003;
   wire [15:0] DIO_RDATA, EE_DATA, LEARN_EN;
   wire [7:0] EE_ADDR;
   wire [3:0] AUTO_ADD_PORT;
   wire DIO_RVALID, EE_REQ, EE_ACK, EE_ERR, AUTO_ADD, MANUAL_ADD;
   wire MATCH_EN, AGING_EN, LOGIC_RESET, TABLE_INIT_BUSY;
   integer err_total = 0;
   integer check_count = 0;
   // Short base interval: 20 cycles, plus 4 per entry of RAM_SIZE 3
   mode_control_learn_disable #(.INIT_BASE_NS(200))
      i_mode_control_learn_disable (
      .CLOCK(CLOCK), .RST_N(RST_N), .DIO_ADDR(DIO_ADDR),
      .DIO_WDATA(DIO_WDATA), .DIO_WR(DIO_WR), .DIO_RD(DIO_RD),
      .DIO_HI_WR(DIO_HI_WR), .DIO_HI_DATA(DIO_HI_DATA),
      .DIO_RDATA(DIO_RDATA), .DIO_RVALID(DIO_RVALID),
      .EE_ABSENT(EE_ABSENT), .EE_REQ(EE_REQ), .EE_ADDR(EE_ADDR),
      .EE_ACK(EE_ACK), .EE_ERR(EE_ERR), .EE_DATA(EE_DATA),
      .RAM_SIZE(RAM_SIZE), .SRC_UNKNOWN(SRC_UNKNOWN),
      .SRC_PORT(SRC_PORT), .ADD_CMD(ADD_CMD), .AUTO_ADD(AUTO_ADD),
      .AUTO_ADD_PORT(AUTO_ADD_PORT), .MANUAL_ADD(MANUAL_ADD),
      .LEARN_EN(LEARN_EN), .MATCH_EN(MATCH_EN), .AGING_EN(AGING_EN),
      .LOGIC_RESET(LOGIC_RESET), .TABLE_INIT_BUSY(TABLE_INIT_BUSY));
   ee_partner i_ee_partner (.clk(CLOCK), .req(EE_REQ),
      .addr(EE_ADDR), .fail(ee_fail), .ack(EE_ACK), .err(EE_ERR),
      .data(EE_DATA));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 CLOCK = ~CLOCK;
   end
   task end_sim;
      begin
         $display("checks %0d errors %0d", check_count, err_total);
         if (err_total == 0 && check_count > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task wr(input [7:0] a, input [15:0] d);
      begin
         @(negedge CLOCK);
         DIO_ADDR = a;
         DIO_WDATA = d;
         DIO_WR = 1'b1;
         @(negedge CLOCK);
         DIO_WR = 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [15:0] e);
      begin
         @(negedge CLOCK);
         DIO_ADDR = a;
         DIO_RD = 1'b1;
         @(negedge CLOCK);
         DIO_RD = 1'b0;
         `CHK(DIO_RVALID, 1'b1)
         `CHK(DIO_RDATA, e)
      end
   endtask
   task hi(input [7:0] v);
      begin
         @(negedge CLOCK);
         DIO_HI_DATA = v;
         DIO_HI_WR = 1'b1;
         @(negedge CLOCK);
         DIO_HI_WR = 1'b0;
      end
   endtask
   // Bounded wait for a load sequence to run out
   task ld;
      integer i;
      begin
         repeat (6) @(negedge CLOCK);
         for (i = 0; i < 200 && EE_REQ === 1'b1; i = i + 1)
            @(negedge CLOCK);
         repeat (4) @(negedge CLOCK);
      end
   endtask
   task initm(input integer e);
      integer n;
      begin
         for (n = 0; n < 20 && TABLE_INIT_BUSY !== 1'b1; n = n + 1)
            @(negedge CLOCK);
         n = 0;
         while (TABLE_INIT_BUSY === 1'b1 && n < 999) begin
            n = n + 1;
            @(negedge CLOCK);
         end
         `CHK(n, e)
         repeat (2) @(negedge CLOCK);
      end
   endtask
   task add(input u, input c, input [3:0] p, input ea, input em);
      begin
         @(negedge CLOCK);
         SRC_UNKNOWN = u;
         ADD_CMD = c;
         SRC_PORT = p;
         @(negedge CLOCK);
         SRC_UNKNOWN = 1'b0;
         ADD_CMD = 1'b0;
         `CHK(AUTO_ADD, ea)
         `CHK(MANUAL_ADD, em)
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(negedge CLOCK);
      RST_N = 1'b1;
      ld;
      rd(8'h04, 16'h00a5);
      rd(8'h08, 16'h0400);
      wr(8'h08, 16'h1800);
      rd(8'h08, 16'h0000);
      wr(8'h04, 16'h1234);
      rd(8'h04, 16'h1234);
      wr(8'h08, 16'h2000);
      initm(32);
      rd(8'h08, 16'h3000);
      `CHK(AGING_EN, 1'b1)
      `CHK(LEARN_EN, 16'hedcb)
      wr(8'h04, 16'h0006);
      rd(8'h04, 16'h0006);
      wr(8'h08, 16'h0000);
      rd(8'h08, 16'h3000);
      add(1'b1, 1'b0, 4'h3, 1'b1, 1'b0);
      `CHK(AUTO_ADD_PORT, 4'h3)
      add(1'b1, 1'b0, 4'h2, 1'b0, 1'b0);
      wr(8'h08, 16'h8000);
      rd(8'h04, 16'h0000);
      rd(8'h08, 16'h8000);
      `CHK(MATCH_EN, 1'b0)
      wr(8'h08, 16'h0400);
      rd(8'h08, 16'h0400);
      `CHK(LOGIC_RESET, 1'b0)
      RAM_SIZE = 16'h0005;
      wr(8'h08, 16'h2400);
      initm(40);
      `CHK(AGING_EN, 1'b0)
      add(1'b1, 1'b0, 4'h3, 1'b0, 1'b0);
      add(1'b0, 1'b1, 4'h3, 1'b0, 1'b1);
      ee_fail = 1'b1;
      wr(8'h08, 16'h4400);
      rd(8'h08, 16'h7400);
      ld;
      rd(8'h08, 16'h8400);
      `CHK(LOGIC_RESET, 1'b1)
      ee_fail = 1'b0;
      wr(8'h08, 16'h0000);
      rd(8'h08, 16'h0000);
      hi(8'h41);
      ld;
      rd(8'h04, 16'h0000);
      hi(8'h40);
      ld;
      rd(8'h04, 16'h00a5);
      wr(8'h04, 16'h0000);
      wr(8'h08, 16'h4000);
      ld;
      rd(8'h04, 16'h00a5);
      rd(8'h08, 16'h0400);
      EE_ABSENT = 1'b1;
      repeat (4) @(negedge CLOCK);
      rd(8'h08, 16'h0c00);
      // Second pin reset mid-run, taken while soft reset is set
      wr(8'h08, 16'h8000);
      EE_ABSENT = 1'b0;
      RST_N = 1'b0;
      repeat (3) @(negedge CLOCK);
      `CHK(LOGIC_RESET, 1'b0)
      RST_N = 1'b1;
      ld;
      rd(8'h04, 16'h00a5);
      rd(8'h08, 16'h0400);
      end_sim;
   end
   // Run needs under 2000 cycles; this limit only catches a hang
   initial begin
      #100000;
      err_total = err_total + 1;
      end_sim;
   end
endmodule

/* table_init.v */
// Lookup-table initialisation timer that raises the done flag
`timescale 1ns/10ps
`include "learn_ctrl_defs.vh"

module table_init #(
   parameter [23:0] BASE_CYCLES = 24'd4000,
   parameter [3:0] ENTRY_CYCLES = 4'd4
) (
   input wire clk,
   input wire rst_n,
   input wire clear,
   input wire go,
   input wire [15:0] ram_size,
   output reg busy_q,
   output reg done_q
);

   reg [23:0] cnt_q;
   wire [23:0] total;

   // Base interval plus a fixed time per external entry
   assign total = BASE_CYCLES + ram_size * ENTRY_CYCLES; // [R12]

   always @(posedge clk) begin
      if (!rst_n || clear) begin
         cnt_q <= `INIT_CNT_ZERO;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else if (go && !busy_q && !done_q) begin
         cnt_q <= total;
         busy_q <= 1'b1;
      end else if (busy_q) begin
         if (cnt_q <= `INIT_CNT_ONE) begin
            busy_q <= 1'b0;
            done_q <= 1'b1; // [R11]
         end
         cnt_q <= cnt_q - `INIT_CNT_ONE;
      end
   end

endmodule
